/* rtl/bmdt_regs.svh */
// Constants for the board memory decode and bus timeout block.
`ifndef BMDT_REGS_SVH
`define BMDT_REGS_SVH

// ============================================================
// Timing
`define BMDT_CLK_PERIOD_NS   4
`define BMDT_TIMEOUT_MS      10
`define BMDT_TIMEOUT_CYC     ((`BMDT_TIMEOUT_MS * 1000000) / `BMDT_CLK_PERIOD_NS)

// ============================================================
// Address map
`define BMDT_ROM_1K_TOP      16'h03FF
`define BMDT_ROM_2K_TOP      16'h07FF
`define BMDT_ROM_4K_TOP      16'h0FFF
`define BMDT_ROM_8K_TOP      16'h1FFF
`define BMDT_RAM_8K_MIN_SEG  3'h1
`define BMDT_RAM_16K_DEF_SEG 2'h1
`define BMDT_RAM_BYTES       16384
`define BMDT_EXT_SEL_BIT     13

`endif

/* rtl/bmdt_pkg.sv */
// Types shared by the board memory decode and bus timeout block.
package bmdt_pkg;
	typedef enum logic [1:0] {BMDT_ROM_1K, BMDT_ROM_2K, BMDT_ROM_4K} bmdt_rom_size_e;
	typedef enum logic [1:0] {BMDT_TGT_NONE, BMDT_TGT_ROM, BMDT_TGT_RAM, BMDT_TGT_BUS} bmdt_tgt_e;
endpackage : bmdt_pkg

/* rtl/bmdt_decode.sv */
// Processor address decoder for read-only memory, on-board RAM and the system bus.
`timescale 1ns/10ps
`include "bmdt_regs.svh"

module bmdt_decode
	import bmdt_pkg::*;
(
	input  wire logic [15:0]              addr,
	input  wire bmdt_pkg::bmdt_rom_size_e rom_size,
	input  wire logic                     rom_two,
	input  wire logic                     ram_16k,
	input  wire logic [2:0]               ram_seg8,
	input  wire logic [1:0]               ram_seg16,
	output bmdt_pkg::bmdt_tgt_e           tgt,
	output logic                          rom_illegal
);
	logic [15:0] top1;
	logic [15:0] top2;

	// ============================================================
	// Read-only memory window; two parts double the window.
	always_comb
	begin
		unique case (rom_size)
			BMDT_ROM_1K:
			begin
				top1 = `BMDT_ROM_1K_TOP;
				top2 = `BMDT_ROM_2K_TOP;
			end
			BMDT_ROM_2K:
			begin
				top1 = `BMDT_ROM_2K_TOP;
				top2 = `BMDT_ROM_4K_TOP;
			end
			default:
			begin
				top1 = `BMDT_ROM_4K_TOP;
				top2 = `BMDT_ROM_8K_TOP;
			end
		endcase
	end

	// ============================================================
	// Target select; an unfitted second socket still decodes as ROM so a
	// write there is acknowledged like a legal one, only the data is bad.
	always_comb
	begin
		rom_illegal = 1'b0;
		if (addr <= top2)
		begin
			tgt         = BMDT_TGT_ROM;
			rom_illegal = !rom_two && (addr > top1);
		end
		else if (ram_16k ? (addr[15:14] == ram_seg16 && ram_seg16 != 2'h0)
		                 : (addr[15:13] == ram_seg8 && ram_seg8 >= `BMDT_RAM_8K_MIN_SEG))
			tgt = BMDT_TGT_RAM;
		else
			tgt = BMDT_TGT_BUS;
	end
endmodule : bmdt_decode

/* rtl/bmdt_top.sv */
// Board memory cycle control: decode, dual-port RAM arbitration, failsafe timer.
`timescale 1ns/10ps
`include "bmdt_regs.svh"

// Function
// - The failsafe timer restarts in the first state of every processor cycle.
// - With the timer enabled and no acknowledge for 10 ms the processor is released.
// - The expiry output serves as an optional interrupt and panel indicator drive.
// - With the timer disabled a missing acknowledge stalls until system reset.
// - The board holds 16K bytes of RAM and up to 8K bytes of read-only memory.
// - ROM answers only the processor; RAM answers the processor and the bus owner.
// - Processor and external RAM accesses interleave; the processor waits its turn.
// - With 1K parts ROM is 0000-03FF or 0000-07FF; 0400-07FF is illegal with one part.
// - With 2K parts ROM is 0000-07FF or 0000-0FFF; 0800-0FFF is illegal with one part.
// - With 4K parts ROM is 0000-0FFF or 0000-1FFF; 1000-1FFF is illegal with one part.
// - In 8K mode the RAM block is any 8K-aligned range from 2000 up to E000.
// - In 16K mode the RAM block is 4000, 8000 or C000, default 4000.
// - A processor address outside the selected block goes out on the system bus.
// - On-board ROM accesses get an internal early acknowledge with no wait; RAM accesses get none.
// - Off-board accesses win the bus, issue the command and wait for the acknowledge.
// - A write to an illegal ROM address is still acknowledged early.
module bmdt_top
	import bmdt_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `BMDT_TIMEOUT_CYC
)
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	input  wire logic                     cyc_start,
	input  wire logic                     cpu_rd,
	input  wire logic                     cpu_wr,
	input  wire logic [15:0]              cpu_addr,
	input  wire logic [7:0]               cpu_wdata,
	output logic      [7:0]               cpu_rdata,
	output logic                          cpu_ready,
	output logic                          early_ack_n,
	input  wire logic                     failsafe_en,
	input  wire bmdt_pkg::bmdt_rom_size_e rom_size,
	input  wire logic                     rom_two,
	input  wire logic                     ram_16k,
	input  wire logic [2:0]               ram_seg8,
	input  wire logic [1:0]               ram_seg16,
	output logic      [12:0]              rom_addr,
	input  wire logic [7:0]               rom_rdata,
	output logic                          bus_req,
	input  wire logic                     bus_grant,
	output logic                          bus_cmd,
	input  wire logic                     transfer_ack_n,
	input  wire logic [7:0]               bus_rdata,
	input  wire logic                     ext_req,
	input  wire logic                     ext_wr,
	input  wire logic [13:0]              ext_addr,
	input  wire logic [7:0]               ext_wdata,
	output logic      [7:0]               ext_rdata,
	output logic                          ext_ack,
	output logic                          bus_timeout_out,
	output logic                          timeout_irq,
	output logic                          timeout_led
);
	typedef enum logic [2:0] {ST_IDLE, ST_RAM, ST_BUSREQ, ST_BUSWAIT, ST_DONE} bmdt_st_e;

	bmdt_st_e    st_q;
	bmdt_tgt_e   tgt;
	logic        rom_illegal;
	logic [7:0]  ram_mem [0:`BMDT_RAM_BYTES-1];
	logic [31:0] tmr_q;
	logic        expired;
	logic        ext_turn_q;
	logic        cpu_ram_go;
	logic        ext_go;
	logic [2:0]  transfer_ack_n_sync_q;
	logic        transfer_ack_n_lvl_q;
	logic        cpu_req;
	logic [13:0] ram_idx;

	assign cpu_req = cpu_rd | cpu_wr;
	// In 8K mode the processor only reaches the lower half of the array.
	assign ram_idx = ram_16k ? cpu_addr[13:0]
	                         : {1'b0, cpu_addr[12:0]};

	// ============================================================
	// Address decode.
	bmdt_decode u_dec (
		.addr        (cpu_addr),
		.rom_size    (rom_size),
		.rom_two     (rom_two),
		.ram_16k     (ram_16k),
		.ram_seg8    (ram_seg8),
		.ram_seg16   (ram_seg16),
		.tgt         (tgt),
		.rom_illegal (rom_illegal)
	);

	// ============================================================
	// Acknowledge from the bus is a pin, so it passes three flops.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			transfer_ack_n_sync_q <= 3'h7;
			transfer_ack_n_lvl_q  <= 1'b0;
		end
		else
		begin
			transfer_ack_n_sync_q <= {transfer_ack_n_sync_q[1:0], transfer_ack_n};
			if (transfer_ack_n_sync_q[2] == transfer_ack_n_sync_q[1])
				transfer_ack_n_lvl_q <= !transfer_ack_n_sync_q[1];
		end
	end

	// ============================================================
	// Dual-port arbitration: alternate turns so neither side starves.
	assign cpu_ram_go = (st_q == ST_RAM) && !(ext_req && ext_turn_q);
	assign ext_go     = ext_req && !(st_q == ST_RAM && !ext_turn_q);

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			ext_turn_q <= 1'b0;
		else if (ext_go)
			ext_turn_q <= 1'b0;
		else if (cpu_ram_go)
			ext_turn_q <= 1'b1;
	end

	// ============================================================
	// RAM array, one port taken per clock; ROM never seen by the bus.
	always_ff @(posedge sys_clk)
	begin
		if (ext_go && ext_wr)
			ram_mem[ext_addr] <= ext_wdata;
		else if (cpu_ram_go && cpu_wr)
			ram_mem[ram_idx] <= cpu_wdata;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ext_rdata <= 8'h00;
			ext_ack   <= 1'b0;
		end
		else
		begin
			ext_ack <= ext_go;
			if (ext_go)
				ext_rdata <= ram_mem[ext_addr];
		end
	end

	// ============================================================
	// Processor cycle state machine.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q      <= ST_IDLE;
			cpu_rdata <= 8'h00;
		end
		else if (cyc_start)
			st_q <= ST_IDLE;
		else
		begin
			unique case (st_q)
				ST_IDLE:
				begin
					if (cpu_req && tgt == BMDT_TGT_ROM)
					begin
						cpu_rdata <= rom_rdata;
						st_q      <= ST_DONE;
					end
					else if (cpu_req && tgt == BMDT_TGT_RAM)
						st_q <= ST_RAM;
					else if (cpu_req)
						st_q <= ST_BUSREQ;
				end
				ST_RAM:
					if (cpu_ram_go)
					begin
						cpu_rdata <= ram_mem[ram_idx];
						st_q      <= ST_DONE;
					end
				ST_BUSREQ:
					if (expired)
						st_q <= ST_DONE;
					else if (bus_grant)
						st_q <= ST_BUSWAIT;
				ST_BUSWAIT:
					if (transfer_ack_n_lvl_q)
					begin
						cpu_rdata <= bus_rdata;
						st_q      <= ST_DONE;
					end
					else if (expired)
						st_q <= ST_DONE;
				ST_DONE:
					st_q <= ST_DONE;
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	assign bus_req     = (st_q == ST_BUSREQ) || (st_q == ST_BUSWAIT);
	assign bus_cmd     = (st_q == ST_BUSWAIT);
	assign cpu_ready   = (st_q == ST_DONE);
	assign early_ack_n = !(cpu_req && st_q == ST_IDLE && tgt == BMDT_TGT_ROM);
	assign rom_addr    = cpu_addr[12:0];

	// ============================================================
	// Failsafe timer; with it disabled the wait is only left by reset.
	assign expired = failsafe_en && (tmr_q >= TIMEOUT_CYC - 1);

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			tmr_q <= 32'h0000_0000;
		else if (cyc_start)
			tmr_q <= 32'h0000_0000;
		else if (bus_req && !expired)
			tmr_q <= tmr_q + 32'h0000_0001;
	end

	// Flag holds until the next cycle starts.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			bus_timeout_out <= 1'b0;
		else if (bus_req && expired && !(bus_cmd && transfer_ack_n_lvl_q))
			bus_timeout_out <= 1'b1;
		else if (cyc_start)
			bus_timeout_out <= 1'b0;
	end

	assign timeout_irq = bus_timeout_out;
	assign timeout_led = bus_timeout_out;

	// ============================================================
	// Checks.
	a_timer_restart: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cyc_start |=> tmr_q == 32'h0000_0000) else $error("timer not restarted");
	a_expiry_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q == ST_BUSWAIT && expired && !transfer_ack_n_lvl_q && !cyc_start) |=> cpu_ready)
		else $error("expiry did not release");
	a_flag_drives: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(bus_timeout_out) |-> $past(expired) && timeout_irq && timeout_led)
		else $error("indicator mismatch");
	a_illegal_ack: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q == ST_IDLE && cpu_req && rom_illegal && !cyc_start)
		|-> !early_ack_n ##1 cpu_ready) else $error("illegal rom stalled");
	a_no_release_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!failsafe_en && st_q == ST_BUSWAIT && !transfer_ack_n_lvl_q && !cyc_start) |=> !cpu_ready)
		else $error("released without ack");
	a_rom_no_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q == ST_IDLE && cpu_req && tgt == BMDT_TGT_ROM && !cyc_start)
		|-> !early_ack_n ##1 cpu_ready) else $error("rom wait inserted");
	a_ext_served: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(ext_req && st_q != ST_RAM) |=> ext_ack) else $error("ext not served");
	a_interleave: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q == ST_RAM && !cyc_start) |-> ##[0:2] cpu_ram_go)
		else $error("cpu locked out");
	a_flag_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(bus_timeout_out && !cyc_start) |=> bus_timeout_out)
		else $error("flag dropped early");
	a_bus_cmd_grant: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(bus_cmd) |-> $past(bus_grant)) else $error("cmd without grant");
	a_off_board: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q == ST_IDLE && cpu_req && tgt == BMDT_TGT_BUS && !cyc_start) |=> bus_req)
		else $error("no bus request");
endmodule : bmdt_top

/* sim/bmdt_sysbus_mem.sv */
// Behavioural model of an arbiter and a slow memory on the shared system bus.
`timescale 1ns/10ps

module bmdt_sysbus_mem
(
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       bus_req,
	input  wire logic       bus_cmd,
	input  wire logic       ack_en,
	input  wire logic [3:0] ack_dly,
	input  wire logic [7:0] mem_data,
	output logic            bus_grant,
	output logic            transfer_ack_n,
	output logic [7:0]      bus_rdata
);
	// ============================================================
	// Arbiter and memory
	logic [3:0] wait_q;

	// Grant trails the request by one cycle, as a bus with no other owner would.
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			bus_grant <= 1'b0;
		else
			bus_grant <= bus_req;

	// Acknowledge after a chosen delay; with ack_en low the memory is dead and never answers.
	// Released data shows the inverse so a stale sample can never pass for a read.
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			wait_q         <= 4'h0;
			transfer_ack_n <= 1'b1;
			bus_rdata      <= 8'h00;
		end
		else if (!bus_cmd || !ack_en)
		begin
			wait_q         <= 4'h0;
			transfer_ack_n <= 1'b1;
			bus_rdata      <= ~mem_data;
		end
		else if (wait_q == ack_dly)
		begin
			transfer_ack_n <= 1'b0;
			bus_rdata      <= mem_data;
		end
		else
			wait_q <= wait_q + 4'h1;
endmodule : bmdt_sysbus_mem

/* sim/bmdt_top_tb.sv */
// Self-checking testbench for the board memory decode and bus timeout block.
`timescale 1ns/10ps

module bmdt_top_tb;
	import bmdt_pkg::*;
	// ============================================================
	// Stimulus and observation signals
	logic sys_clk = 0, rst_b = 0, cyc_start = 0, cpu_rd = 0, cpu_wr = 0, failsafe_en = 0;
	logic rom_two = 0, ram_16k = 1, ext_req = 0, ext_wr = 0, ack_en = 1, ea;
	logic bus_req, bus_grant, bus_cmd, transfer_ack_n, cpu_ready, early_ack_n, ext_ack;
	logic bus_timeout_out, timeout_irq, timeout_led;
	logic [15:0] cpu_addr = 16'h0000;
	logic [13:0] ext_addr = 14'h0000;
	logic [12:0] rom_addr;
	logic [7:0]  cpu_wdata = 8'h00, ext_wdata = 8'h00, mem_data = 8'h00, rd;
	logic [7:0]  cpu_rdata, rom_rdata, bus_rdata, ext_rdata;
	logic [3:0]  ack_dly = 4'h0;
	logic [2:0]  ram_seg8 = 3'h1;
	logic [1:0]  ram_seg16 = 2'h1;
	bmdt_rom_size_e rom_size = BMDT_ROM_1K;
	int error_cnt = 0, num_checks = 0, n;

	// Free-running 250 MHz clock; read-only memory data is a pattern of its address.
	always #2 sys_clk = ~sys_clk;
	assign rom_rdata = rom_addr[7:0] ^ 8'h5A;

	bmdt_top #(.TIMEOUT_CYC(50)) dut (.sys_clk, .rst_b, .cyc_start, .cpu_rd, .cpu_wr,
		.cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ready, .early_ack_n, .failsafe_en, .rom_size,
		.rom_two, .ram_16k, .ram_seg8, .ram_seg16, .rom_addr, .rom_rdata, .bus_req, .bus_grant,
		.bus_cmd, .transfer_ack_n, .bus_rdata, .ext_req, .ext_wr, .ext_addr, .ext_wdata,
		.ext_rdata, .ext_ack, .bus_timeout_out, .timeout_irq, .timeout_led);
	bmdt_sysbus_mem mem (.sys_clk, .rst_b, .bus_req, .bus_cmd, .ack_en, .ack_dly, .mem_data,
		.bus_grant, .transfer_ack_n, .bus_rdata);

	// ============================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One machine cycle: start pulse, then a request held until ready or the limit.
	task automatic cpu(input logic wr, input logic [15:0] a, input logic [7:0] d, input int lim);
		@(negedge sys_clk);
		cyc_start = 1'b1;
		@(negedge sys_clk);
		cyc_start = 1'b0;
		{cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = {!wr, wr, a, d};
		#1;
		ea = early_ack_n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (cpu_ready !== 1'b1 && n < lim);
		rd = cpu_rdata;
		@(negedge sys_clk);
		{cpu_rd, cpu_wr} = 2'b00;
	endtask : cpu

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// ============================================================
	// Scenarios
	task automatic t_rom();
		cpu(1'b0, 16'h03FF, 8'h00, 20);
		chk(ea, 1'b0);
		chk(rd, 8'hFF ^ 8'h5A);
		cpu(1'b1, 16'h0400, 8'h11, 20);
		chk({ea, cpu_ready}, 2'b01);
		rom_size = BMDT_ROM_2K;
		rom_two = 1'b1;
		cpu(1'b0, 16'h0FFF, 8'h00, 20);
		chk(ea, 1'b0);
		rom_size = BMDT_ROM_4K;
		rom_two = 1'b0;
		cpu(1'b0, 16'h1000, 8'h00, 20);
		chk(ea, 1'b0);
		{ram_16k, ram_seg8} = {1'b0, 3'h1};
		cpu(1'b0, 16'h2000, 8'h00, 20);
		chk({ea, cpu_ready, n <= 2}, 3'b111);
		$display("test rom done");
	endtask : t_rom

	task automatic t_ram();
		{ram_16k, ram_seg16} = {1'b1, 2'h1};
		cpu(1'b1, 16'h4005, 8'hA5, 20);
		cpu(1'b0, 16'h4005, 8'h00, 20);
		chk(rd, 8'hA5);
		chk(n <= 2, 1'b1);
		{ram_16k, ram_seg8, mem_data, ack_dly} = {1'b0, 3'h7, 8'hC3, 4'h0};
		cpu(1'b1, 16'hE001, 8'h3C, 20);
		cpu(1'b0, 16'hE001, 8'h00, 20);
		chk(rd, 8'h3C);
		cpu(1'b0, 16'h4005, 8'h00, 40);
		chk(rd, 8'hC3);
		{ram_16k, ram_seg16, mem_data, ack_dly} = {1'b1, 2'h3, 8'h96, 4'h5};
		cpu(1'b0, 16'h8000, 8'h00, 40);
		chk({rd, bus_timeout_out}, {8'h96, 1'b0});
		$display("test ram done");
	endtask : t_ram

	task automatic t_tmo();
		{ack_en, failsafe_en, ram_seg16} = {1'b0, 1'b1, 2'h1};
		cpu(1'b0, 16'h9000, 8'h00, 200);
		chk(cpu_ready, 1'b1);
		chk({n >= 50, n <= 60}, 2'b11);
		chk({bus_timeout_out, timeout_irq, timeout_led}, 3'b111);
		@(negedge sys_clk);
		cyc_start = 1'b1;
		@(negedge sys_clk);
		cyc_start = 1'b0;
		chk(bus_timeout_out, 1'b0);
		$display("test timeout done");
	endtask : t_tmo

	task automatic t_ext();
		{ext_req, ext_wr, ext_addr, ext_wdata} = {1'b1, 1'b1, 14'h0005, 8'h77};
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (ext_ack !== 1'b1 && n < 10);
		chk(ext_ack, 1'b1);
		@(negedge sys_clk);
		ext_wr = 1'b0;
		cpu(1'b0, 16'h4005, 8'h00, 10);
		chk({cpu_ready, rd}, {1'b1, 8'h77});
		ext_req = 1'b0;
		chk(ext_rdata, 8'h77);
		$display("test ext done");
	endtask : t_ext

	task automatic t_hang();
		failsafe_en = 1'b0;
		cpu(1'b0, 16'h9000, 8'h00, 200);
		chk({cpu_ready, bus_timeout_out}, 2'b00);
		rst_b = 1'b0;
		@(negedge sys_clk);
		rst_b = 1'b1;
		chk({bus_req, cpu_ready}, 2'b00);
		$display("test hang done");
	endtask : t_hang

	// ============================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		t_rom();
		t_ram();
		t_tmo();
		t_ext();
		t_hang();
		stop_test();
	end

	// The whole run needs well under two thousand cycles; this catches a hang.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		stop_test();
	end
endmodule : bmdt_top_tb
